// ===== hdl/scr_pkg.sv
package scr_pkg;
   // Register byte offsets within the controller window.
   localparam logic [15:0] OFS_FEATURE_LO = 16'h0000;
   localparam logic [15:0] OFS_FEATURE_HI = 16'h0004;
   localparam logic [15:0] OFS_SPEC_REV = 16'h0008;
   localparam logic [15:0] OFS_IRQ_MASK_SET = 16'h000C;
   localparam logic [15:0] OFS_IRQ_MASK_CLEAR = 16'h0010;
   localparam logic [15:0] OFS_CTRL_CONFIG = 16'h0014;
   localparam logic [15:0] OFS_RESERVED_18 = 16'h0018;
   localparam logic [15:0] OFS_CTRL_STATE = 16'h001C;
   localparam logic [15:0] OFS_SUBSYS_RESET = 16'h0020;
   localparam logic [15:0] OFS_ADMIN_SIZES = 16'h0024;
   localparam logic [15:0] OFS_ADMIN_REQ_LO = 16'h0028;
   localparam logic [15:0] OFS_ADMIN_REQ_HI = 16'h002C;
   localparam logic [15:0] OFS_ADMIN_REPLY_LO = 16'h0030;
   localparam logic [15:0] OFS_ADMIN_REPLY_HI = 16'h0034;
   localparam logic [15:0] OFS_BUF_LOCATION = 16'h0038;
   localparam logic [15:0] OFS_BUF_SIZE = 16'h003C;
   localparam logic [15:0] OFS_BELL_BASE = 16'h1000;
   // Base doorbell spacing in bytes before the spacing exponent is applied.
   localparam logic [15:0] BELL_UNIT = 16'h0004;
   // Feature register field positions (full 64-bit register view).
   localparam int PS_MAX_LSB = 52;
   localparam int PS_MIN_LSB = 48;
   localparam int SPACING_LSB = 32;
   localparam int PS_SHIFT_BASE = 12;
   // Controller configuration layout: enable bit and page size field.
   localparam int CFG_EN_BIT = 0;
   localparam int CFG_PS_LSB = 7;
   // Writable masks; bits outside them are reserved and read zero.
   localparam logic [31:0] CFG_WMASK = 32'hFFFF_FFF1;
   localparam logic [31:0] SIZES_WMASK = 32'h0FFF_0FFF;
   localparam logic [31:0] RING_LO_WMASK = 32'hFFFF_F000;
   localparam logic [31:0] BELL_WMASK = 32'h0000_FFFF;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
   localparam logic [31:0] ONE32 = 32'h0000_0001;
endpackage

// ===== hdl/scr_register_map.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Host maps window ordered, mixed-width memory space.
// [R2] Host never issues locked register accesses.
// [R3] Host uses native width or aligned words.
// [R4] One access never spans two registers.
// [R5] Reserved locations and bits read zero.
// [R6] Host must not rely on zero reserved.
// [R7] Feature register at 00h..07h, read-only.
// [R8] Subsystem reset at 20h; 18h reserved.
// [R9] Queue sizes 24h, request base 28h, reply 30h.
// [R10] Buffer location 38h, buffer size 3Ch.
// [R11] Admin request tail doorbell at 1000h.
// [R12] Doorbells spaced by four shifted by exponent.
// [R13] Vendor range follows last supported doorbell.
// [R14] Vendor start fixed by supported doorbell count.
// [R15] Upper page limit field bits 55:52, read-only.
// [R16] Host page size not above the upper limit.
// [R17] Lower page limit field bits 51:48, read-only.
// [R18] Host page size not below the lower limit.
// [R19] Writes to read-only space are silently dropped.
module scr_register_map
   import scr_pkg::*;
#(
   parameter int QUEUE_PAIRS = 4,
   parameter logic [3:0] SPACING_EXP = 4'h0,
   parameter logic [3:0] PS_MAX = 4'h4,
   parameter logic [3:0] PS_MIN = 4'h0,
   parameter logic [15:0] MAX_ENTRIES = 16'h03FF,
   // Arbitrary revision value, no meaning beyond identification.
   parameter logic [31:0] REVISION = 32'h0001_0000,
   parameter logic [31:0] BUF_LOCATION = 32'h0000_0000,
   parameter logic [31:0] BUF_SIZE = 32'h0000_0000
)(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Register access port, one aligned 32-bit word per access.
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   // Vendor-specific range hand-off.
   output logic vendor_sel,
   // Doorbell event output.
   output logic bell_strobe,
   output logic [7:0] bell_index,
   output logic [15:0] bell_value,
   // Controller side state.
   output logic ctrl_enable,
   output logic [31:0] irq_mask,
   output logic subsys_reset_pulse,
   input wire logic ctrl_ready,
   input wire logic ctrl_fatal
);

   // Number of doorbells the controller supports; two per queue pair.
   localparam int BELLS = 2 * QUEUE_PAIRS;

   // Byte offset of the doorbell with the given index.
   function automatic logic [15:0] bell_offset(input int idx);
      bell_offset = OFS_BELL_BASE + 16'(idx * (int'(BELL_UNIT) << SPACING_EXP));
   endfunction

   // Page size code lies within the advertised limits.
   function automatic logic ps_ok(input logic [3:0] code);
      ps_ok = (code >= PS_MIN) && (code <= PS_MAX);
   endfunction

   // Writable state.
   logic [31:0] cfg_q;
   logic [31:0] mask_q;
   logic [31:0] sizes_q;
   logic [63:0] req_base_q;
   logic [63:0] reply_base_q;
   logic [31:0] rdata_q;
   logic rvalid_q;
   logic strobe_q;
   logic [7:0] bindex_q;
   logic [15:0] bvalue_q;
   logic rst_pulse_q;
   logic ps_err_q;

   // Feature register content; spacing and page limits are fixed at build time.
   logic [63:0] feature;
   assign feature = (64'(PS_MAX) << PS_MAX_LSB) // [R15]
                  | (64'(PS_MIN) << PS_MIN_LSB) // [R17]
                  | (64'(SPACING_EXP) << SPACING_LSB)
                  | 64'(MAX_ENTRIES); // [R7]

   // Doorbell decode: the hit index, and whether any doorbell is hit.
   logic bell_hit;
   logic [7:0] bell_hit_idx;
   always_comb begin
      bell_hit = 1'b0;
      bell_hit_idx = 8'h00;
      for (int i = 0; i < BELLS; i++) begin
         if (reg_addr == bell_offset(i)) begin // [R11] [R12]
            bell_hit = 1'b1;
            bell_hit_idx = 8'(i);
         end
      end
   end

   // Vendor range begins right after the last supported doorbell.
   logic [15:0] vendor_start;
   assign vendor_start = bell_offset(BELLS); // [R13] [R14]
   assign vendor_sel = (reg_rd || reg_wr) && (reg_addr >= vendor_start); // [R13]

   // Page size code the host wrote, checked against the limits.
   logic [3:0] cfg_ps;
   assign cfg_ps = cfg_q[CFG_PS_LSB +: 4];

   // Status word: enabled-ready, fatal, enabled-fatal and page-size-violation flags.
   logic [31:0] state_word;
   assign state_word = {28'h0000000, ps_err_q, ctrl_fatal && ctrl_enable,
                        ctrl_fatal, ctrl_ready && ctrl_enable};

   // Read multiplexer; doorbells are write-only and read zero.
   logic [31:0] rd_mux;
   always_comb begin
      if (reg_addr == OFS_FEATURE_LO) begin
         rd_mux = feature[31:0]; // [R7]
      end else if (reg_addr == OFS_FEATURE_HI) begin
         rd_mux = feature[63:32]; // [R7]
      end else if (reg_addr == OFS_SPEC_REV) begin
         rd_mux = REVISION;
      end else if (reg_addr == OFS_IRQ_MASK_SET || reg_addr == OFS_IRQ_MASK_CLEAR) begin
         rd_mux = mask_q;
      end else if (reg_addr == OFS_CTRL_CONFIG) begin
         rd_mux = cfg_q;
      end else if (reg_addr == OFS_CTRL_STATE) begin
         rd_mux = state_word;
      end else if (reg_addr == OFS_SUBSYS_RESET) begin
         rd_mux = ZERO32; // [R8]
      end else if (reg_addr == OFS_ADMIN_SIZES) begin
         rd_mux = sizes_q; // [R9]
      end else if (reg_addr == OFS_ADMIN_REQ_LO) begin
         rd_mux = req_base_q[31:0]; // [R9]
      end else if (reg_addr == OFS_ADMIN_REQ_HI) begin
         rd_mux = req_base_q[63:32];
      end else if (reg_addr == OFS_ADMIN_REPLY_LO) begin
         rd_mux = reply_base_q[31:0]; // [R9]
      end else if (reg_addr == OFS_ADMIN_REPLY_HI) begin
         rd_mux = reply_base_q[63:32];
      end else if (reg_addr == OFS_BUF_LOCATION) begin
         rd_mux = BUF_LOCATION; // [R10]
      end else if (reg_addr == OFS_BUF_SIZE) begin
         rd_mux = BUF_SIZE; // [R10]
      end else begin
         // Reserved space, including 18h and 40h..FFFh, reads zero.
         rd_mux = ZERO32; // [R5]
      end
   end

   // Write decode strobes; doorbell writes are decoded separately, anything else is dropped without effect.
   logic wr_cfg, wr_mset, wr_mclr, wr_sizes, wr_subsys;
   logic wr_req_lo, wr_req_hi, wr_rep_lo, wr_rep_hi;
   assign wr_cfg = reg_wr && reg_addr == OFS_CTRL_CONFIG; // [R19]
   assign wr_mset = reg_wr && reg_addr == OFS_IRQ_MASK_SET;
   assign wr_mclr = reg_wr && reg_addr == OFS_IRQ_MASK_CLEAR;
   assign wr_sizes = reg_wr && reg_addr == OFS_ADMIN_SIZES; // [R9]
   assign wr_subsys = reg_wr && reg_addr == OFS_SUBSYS_RESET; // [R8]
   assign wr_req_lo = reg_wr && reg_addr == OFS_ADMIN_REQ_LO;
   assign wr_req_hi = reg_wr && reg_addr == OFS_ADMIN_REQ_HI;
   assign wr_rep_lo = reg_wr && reg_addr == OFS_ADMIN_REPLY_LO;
   assign wr_rep_hi = reg_wr && reg_addr == OFS_ADMIN_REPLY_HI;

   // Configuration and mask registers.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cfg_q <= ZERO32;
         mask_q <= ZERO32;
      end else begin
         // Reserved configuration bits never store.
         if (wr_cfg) begin
            cfg_q <= reg_wdata & CFG_WMASK; // [R5]
         end
         // Set and clear of mask bits come through separate words.
         if (wr_mset) begin
            mask_q <= mask_q | reg_wdata;
         end else if (wr_mclr) begin
            mask_q <= mask_q & ~reg_wdata;
         end
      end
   end

   // Admin queue registers; low ring base bits are page aligned and read zero.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sizes_q <= ZERO32;
         req_base_q <= 64'h0;
         reply_base_q <= 64'h0;
      end else begin
         if (wr_sizes) sizes_q <= reg_wdata & SIZES_WMASK; // [R9] [R5]
         if (wr_req_lo) req_base_q[31:0] <= reg_wdata & RING_LO_WMASK; // [R9]
         if (wr_req_hi) req_base_q[63:32] <= reg_wdata;
         if (wr_rep_lo) reply_base_q[31:0] <= reg_wdata & RING_LO_WMASK; // [R9]
         if (wr_rep_hi) reply_base_q[63:32] <= reg_wdata;
      end
   end

   // Subsystem reset: pulses for one cycle when the key word is written.
   // Arbitrary key value; any other word is ignored so a stray write cannot reset.
   localparam logic [31:0] RESET_KEY = 32'h0000_5AA5;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rst_pulse_q <= 1'b0;
      end else begin
         rst_pulse_q <= wr_subsys && (reg_wdata == RESET_KEY); // [R8]
      end
   end

   // Page size check: flag a configuration outside the advertised limits.
   // The host is obliged to stay inside them; the flag helps catch a bad driver.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ps_err_q <= 1'b0;
      end else if (wr_cfg) begin
         ps_err_q <= !ps_ok(reg_wdata[CFG_PS_LSB +: 4]); // [R16] [R18]
      end
   end

   // Doorbell event strobe; doorbells are write-only, so only the last write is kept.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         strobe_q <= 1'b0;
         bindex_q <= 8'h00;
         bvalue_q <= 16'h0000;
      end else begin
         strobe_q <= reg_wr && bell_hit; // [R12]
         if (reg_wr && bell_hit) begin
            bindex_q <= bell_hit_idx; // [R11]
            bvalue_q <= reg_wdata[15:0] & BELL_WMASK[15:0];
         end
      end
   end

   // Read data register; a read answers one cycle later.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rdata_q <= ZERO32;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= reg_rd;
         if (reg_rd) rdata_q <= rd_mux; // [R5]
      end
   end

   // Outputs.
   assign reg_rdata = rdata_q;
   assign reg_rvalid = rvalid_q;
   assign bell_strobe = strobe_q;
   assign bell_index = bindex_q;
   assign bell_value = bvalue_q;
   assign ctrl_enable = cfg_q[CFG_EN_BIT];
   assign irq_mask = mask_q;
   assign subsys_reset_pulse = rst_pulse_q;

   // Reads of reserved space return zero one cycle later.
   property p_reserved_zero;
      @(posedge sys_clk) disable iff (sys_rst)
      (reg_rd && reg_addr >= 16'h0040 && reg_addr < OFS_BELL_BASE) |=> (reg_rdata == ZERO32);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved nonzero"); // [R5]

   // Offset 18h is reserved.
   property p_res18;
      @(posedge sys_clk) disable iff (sys_rst)
      (reg_rd && reg_addr == OFS_RESERVED_18) |=> (reg_rdata == ZERO32);
   endproperty
   a_res18: assert property (p_res18) else $error("offset 18h not zero"); // [R8]

   // Feature upper word shows both page limits.
   property p_ps_fields;
      @(posedge sys_clk) disable iff (sys_rst)
      (reg_rd && reg_addr == OFS_FEATURE_HI) |=>
         (reg_rdata[23:20] == PS_MAX && reg_rdata[19:16] == PS_MIN);
   endproperty
   a_ps_fields: assert property (p_ps_fields) else $error("page limits wrong"); // [R15]

   // Feature low word always reads its fixed content, whatever was written to it.
   property p_feature_ro;
      @(posedge sys_clk) disable iff (sys_rst)
      (reg_rd && reg_addr == OFS_FEATURE_LO) |=> (reg_rdata == {16'h0000, MAX_ENTRIES});
   endproperty
   a_feature_ro: assert property (p_feature_ro) else $error("feature changed"); // [R7]

   // Admin doorbell write produces strobe with index zero next cycle.
   property p_admin_bell;
      @(posedge sys_clk) disable iff (sys_rst)
      (reg_wr && reg_addr == OFS_BELL_BASE) |=> (bell_strobe && bell_index == 8'h00);
   endproperty
   a_admin_bell: assert property (p_admin_bell) else $error("admin bell missed"); // [R11]

   // Reply bell of pair zero sits one spacing above the base.
   property p_reply_bell;
      @(posedge sys_clk) disable iff (sys_rst)
      (reg_wr && reg_addr == OFS_BELL_BASE + (BELL_UNIT << SPACING_EXP)) |=>
         (bell_strobe && bell_index == 8'h01);
   endproperty
   a_reply_bell: assert property (p_reply_bell) else $error("reply bell missed"); // [R12]

   // Writes in reserved space leave configuration and no strobe.
   property p_ro_drop;
      @(posedge sys_clk) disable iff (sys_rst)
      (reg_wr && reg_addr >= 16'h0040 && reg_addr < OFS_BELL_BASE) |=>
         (!bell_strobe && $stable(cfg_q) && $stable(sizes_q));
   endproperty
   a_ro_drop: assert property (p_ro_drop) else $error("reserved write had effect"); // [R19]

   // Vendor selection starts exactly past the last doorbell.
   property p_vendor;
      @(posedge sys_clk) disable iff (sys_rst)
      ((reg_rd || reg_wr) && reg_addr == OFS_BELL_BASE + 16'(BELLS) * (BELL_UNIT << SPACING_EXP))
         |-> (vendor_sel && !bell_hit);
   endproperty
   a_vendor: assert property (p_vendor) else $error("vendor start wrong"); // [R14]

   // Buffer size register returns its fixed value.
   property p_buf_size;
      @(posedge sys_clk) disable iff (sys_rst)
      (reg_rd && reg_addr == OFS_BUF_SIZE) |=> (reg_rdata == BUF_SIZE);
   endproperty
   a_buf_size: assert property (p_buf_size) else $error("buffer size wrong"); // [R10]

   // A write into the gap above a doorbell rings nothing when the spacing is wide.
   property p_bell_gap;
      @(posedge sys_clk) disable iff (sys_rst)
      (reg_wr && SPACING_EXP != 4'h0 && reg_addr == OFS_BELL_BASE + BELL_UNIT)
         |=> !bell_strobe;
   endproperty
   a_bell_gap: assert property (p_bell_gap) else $error("gap write rang a bell"); // [R12]

   // The page size flag follows the stored code against both advertised limits.
   property p_ps_flag;
      @(posedge sys_clk) disable iff (sys_rst)
      (reg_wr && reg_addr == OFS_CTRL_CONFIG) |=>
         (ps_err_q == ((cfg_ps < PS_MIN) || (cfg_ps > PS_MAX)));
   endproperty
   a_ps_flag: assert property (p_ps_flag) else $error("page size flag wrong"); // [R16] [R18]

endmodule

// ===== test/scr_host_model.sv
`timescale 1ns/1ps
// Host software stand-in: one aligned word per request, held for one clock cycle.
module scr_host_model (
   // Clock.
   input wire logic sys_clk,
   // Requests toward the register map.
   output logic reg_wr,
   output logic reg_rd,
   output logic [15:0] reg_addr,
   output logic [31:0] reg_wdata,
   // Answers from the register map.
   input wire logic [31:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic vendor_sel
);
   // Vendor range flag seen while the last request was on the bus.
   logic sel_seen;

   // Idle lines at time zero.
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 32'h0000_0000;
      sel_seen = 1'b0;
   end

   // Whole aligned words only, never locked and never split across registers.
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      #1 sel_seen = vendor_sel;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      // Released lines show the inverse so a stale value never looks valid.
      reg_addr <= ~a;
      reg_wdata <= ~d;
      #1;
   endtask

   // Read data is taken as returned; reserved zeros are not relied upon.
   task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic ok);
      ok = 1'b0;
      d = 32'h0000_0000;
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      #1 sel_seen = vendor_sel;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      // A short bounded wait; the answer is due in the very next cycle.
      for (int n = 0; n < 3 && !ok; n++) begin
         #1;
         if (reg_rvalid === 1'b1) begin
            ok = 1'b1;
            d = reg_rdata;
         end else begin
            @(posedge sys_clk);
         end
      end
   endtask
endmodule

// ===== test/scr_register_map_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module scr_register_map_tb;
   import scr_pkg::*;
   // Eight-byte doorbell spacing makes gaps between doorbells visible.
   localparam int T_PAIRS = 4;
   localparam logic [3:0] T_SPACING = 4'h1;
   localparam logic [3:0] T_PS_MAX = 4'h4;
   localparam logic [3:0] T_PS_MIN = 4'h1;
   localparam logic [15:0] T_ENTRIES = 16'h03FF;
   localparam logic [31:0] T_LOC = 32'h0000_0005;
   localparam logic [31:0] T_SIZE = 32'h0000_00A1;
   localparam logic [15:0] STEP = BELL_UNIT << T_SPACING;
   localparam logic [15:0] VEND = OFS_BELL_BASE + STEP * 16'(2 * T_PAIRS);
   // Arbitrary key value, the same word the design is built to accept.
   localparam logic [31:0] RST_KEY = 32'h0000_5AA5;
   logic sys_clk, sys_rst, ctrl_ready, ctrl_fatal, reg_wr, reg_rd, reg_rvalid, vendor_sel;
   logic bell_strobe, ctrl_enable, subsys_reset_pulse, ok;
   logic [15:0] reg_addr, bell_value;
   logic [31:0] reg_wdata, reg_rdata, irq_mask, rdat;
   logic [7:0] bell_index;
   int errors, checks;

   // Free-running 125 MHz clock.
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   scr_host_model u_host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .vendor_sel(vendor_sel));

   scr_register_map #(.QUEUE_PAIRS(T_PAIRS), .SPACING_EXP(T_SPACING), .PS_MAX(T_PS_MAX),
      .PS_MIN(T_PS_MIN), .MAX_ENTRIES(T_ENTRIES), .BUF_LOCATION(T_LOC), .BUF_SIZE(T_SIZE)) dut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .vendor_sel(vendor_sel), .bell_strobe(bell_strobe),
      .bell_index(bell_index), .bell_value(bell_value), .ctrl_enable(ctrl_enable),
      .irq_mask(irq_mask), .subsys_reset_pulse(subsys_reset_pulse),
      .ctrl_ready(ctrl_ready), .ctrl_fatal(ctrl_fatal));

   // Verdict and end of run.
   task automatic close_out();
      if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Read one word; a missing answer ends the run at once.
   task automatic rd_w(input logic [15:0] a);
      u_host.rd(a, rdat, ok);
      if (ok !== 1'b1) begin
         errors++;
         $display("[FAIL] read answer expected 1 seen 0");
         close_out();
      end
   endtask

   // The feature words stay fixed, also after the host tries to overwrite them.
   task automatic t_feature();
      for (int p = 0; p < 2; p++) begin
         if (p == 1) begin
            u_host.wr(OFS_FEATURE_LO, 32'hFFFF_FFFF);
            u_host.wr(OFS_FEATURE_HI, 32'hFFFF_FFFF);
         end
         rd_w(OFS_FEATURE_LO);
         `CHK("entries", {16'h0000, T_ENTRIES}, rdat)
         rd_w(OFS_FEATURE_HI);
         `CHK("page limits", {8'h00, T_PS_MAX, T_PS_MIN}, rdat[31:16])
         `CHK("spacing", {12'h000, T_SPACING}, rdat[15:0])
      end
   endtask

   // Reserved words and the subsystem reset word without its key swallow writes and read zero.
   task automatic t_reserved();
      logic [15:0] lst [5] = '{OFS_RESERVED_18, OFS_SUBSYS_RESET, 16'h0040, 16'h0EFC, 16'h0FFC};
      foreach (lst[i]) begin
         u_host.wr(lst[i], 32'hFFFF_FFFF);
         `CHK("no effect", 3'b000, {bell_strobe, subsys_reset_pulse, u_host.sel_seen})
         rd_w(lst[i]);
         `CHK("reserved read", ZERO32, rdat)
      end
   endtask

   // Page sizes on both sides of each limit; the host oversteps on purpose.
   task automatic t_config();
      logic [31:0] cfg [6] = '{32'hFFFF_FFFF, 32'h0000_0281, 32'h0000_0201, 32'h0000_0001,
         32'h0000_0081, 32'h0000_0080};
      logic bad;
      @(posedge sys_clk);
      ctrl_ready <= 1'b1;
      ctrl_fatal <= 1'b1;
      foreach (cfg[i]) begin
         bad = (cfg[i][10:7] > T_PS_MAX) || (cfg[i][10:7] < T_PS_MIN);
         u_host.wr(OFS_CTRL_CONFIG, cfg[i]);
         `CHK("enable", cfg[i][0], ctrl_enable)
         rd_w(OFS_CTRL_CONFIG);
         `CHK("config", cfg[i] & CFG_WMASK, rdat)
         rd_w(OFS_CTRL_STATE);
         `CHK("status", {28'h0, bad, cfg[i][0], 1'b1, cfg[i][0]}, rdat)
      end
   endtask

   // All admin words are written first, so any aliasing shows on read-back.
   task automatic t_admin();
      logic [15:0] ofs [7] = '{OFS_ADMIN_SIZES, OFS_ADMIN_REQ_LO, OFS_ADMIN_REQ_HI,
         OFS_ADMIN_REPLY_LO, OFS_ADMIN_REPLY_HI, OFS_BUF_LOCATION, OFS_BUF_SIZE};
      logic [31:0] msk [7] = '{SIZES_WMASK, RING_LO_WMASK, 32'hFFFF_FFFF, RING_LO_WMASK,
         32'hFFFF_FFFF, ZERO32, ZERO32};
      logic [31:0] fix [7] = '{ZERO32, ZERO32, ZERO32, ZERO32, ZERO32, T_LOC, T_SIZE};
      foreach (ofs[i]) u_host.wr(ofs[i], 32'h5A5A_5A5A ^ 32'(i));
      foreach (ofs[i]) begin
         rd_w(ofs[i]);
         `CHK("admin word", fix[i] | ((32'h5A5A_5A5A ^ 32'(i)) & msk[i]), rdat)
      end
   endtask

   // Mask set and clear act on single bits and read back the live mask.
   task automatic t_irq();
      u_host.wr(OFS_IRQ_MASK_SET, 32'hA5A5_0000);
      u_host.wr(OFS_IRQ_MASK_CLEAR, 32'h8001_0000);
      `CHK("mask", 32'h25A4_0000, irq_mask)
      rd_w(OFS_IRQ_MASK_CLEAR);
      `CHK("mask read", 32'h25A4_0000, rdat)
   endtask

   // The reset key gives one pulse of one cycle, checked on the pulse output.
   task automatic t_subsys();
      u_host.wr(OFS_SUBSYS_RESET, RST_KEY);
      `CHK("reset pulse", 1'b1, subsys_reset_pulse)
      @(posedge sys_clk);
      #1;
      `CHK("pulse width", 1'b0, subsys_reset_pulse)
   endtask

   // Every supported doorbell, then a write into the gap between two of them.
   task automatic t_bells();
      for (int i = 0; i < 2 * T_PAIRS; i++) begin
         u_host.wr(OFS_BELL_BASE + STEP * 16'(i), {16'hFFFF, 8'(i), 8'hC3});
         `CHK("bell strobe", 1'b1, bell_strobe)
         `CHK("bell word", {8'(i), 8'(i), 8'hC3}, {bell_index, bell_value})
         rd_w(OFS_BELL_BASE + STEP * 16'(i));
         `CHK("bell read", ZERO32, rdat)
      end
      u_host.wr(OFS_BELL_BASE + BELL_UNIT, ONE32);
      `CHK("gap", 1'b0, bell_strobe)
   endtask

   // The vendor range starts right after the last supported doorbell.
   task automatic t_vendor();
      u_host.wr(VEND - BELL_UNIT, ONE32);
      `CHK("before vendor", 2'b00, {u_host.sel_seen, bell_strobe})
      u_host.wr(VEND, ONE32);
      `CHK("vendor", 2'b10, {u_host.sel_seen, bell_strobe})
   endtask

   // A hang counts as a mismatch and ends the run.
   initial begin
      repeat (50000) @(posedge sys_clk);
      errors++;
      close_out();
   end

   // Main sequence after six cycles of reset.
   initial begin
      errors = 0;
      checks = 0;
      sys_rst = 1'b1;
      ctrl_ready = 1'b0;
      ctrl_fatal = 1'b0;
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_feature();
      t_reserved();
      t_config();
      t_admin();
      t_irq();
      t_subsys();
      t_bells();
      t_vendor();
      close_out();
   end
endmodule
